// ==== hdl/mlic_level_arb.sv ====
`timescale 1ns/1ps

module mlic_level_arb import mlic_pkg::*; #(
  parameter int unsigned N  = 8,
  parameter int unsigned IW = 3
) (
  input  wire logic [N-1:0]            req_i,   // Pending sources of this level
  input  wire logic [N-1:0][VEC_W-1:0] vec_i,   // Table vector per source
  input  wire logic                    rr_en_i, // Rotating priority
  input  wire logic [IW-1:0]           last_i,  // Last served source
  output logic                         valid_o, // Some source pending
  output logic [IW-1:0]                idx_o    // Chosen source
);

  // The index must name every source
  if (N < 1 || N > (1 << IW)) begin : g_bad_n
    $error("N does not fit the index width");
  end

  always_comb begin
    logic [VEC_W-1:0] best;
    int               pos;
    best    = '1;
    pos     = 0;
    valid_o = 1'b0;
    idx_o   = '0;
    if (rr_en_i) begin
      // Start just after the last served one, so it ranks last
      for (int k = 0; k < N; k++) begin
        pos = (int'(last_i) + 1 + k) % N;
        if (!valid_o && req_i[pos]) begin
          valid_o = 1'b1;
          idx_o   = IW'(pos);
        end
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (req_i[i] && (!valid_o || vec_i[i] < best)) begin
          valid_o = 1'b1;
          idx_o   = IW'(i);
          best    = vec_i[i];
        end
      end
    end
  end

endmodule // mlic_level_arb

// ==== hdl/mlic_pkg.sv ====
package mlic_pkg;

  // ----------------------------------------------------------------
  // Vector map, program word addresses
  // ----------------------------------------------------------------
  localparam int unsigned VEC_W = 12;

  localparam logic [11:0] RESET_VECTOR              = 12'h000;
  localparam logic [11:0] OSC_FAIL_VECTOR           = 12'h002;
  localparam logic [11:0] PORT_C_VECTOR_BASE        = 12'h004;
  localparam logic [11:0] TIMER_C_TYPE0_VECTOR_BASE = 12'h01C;
  localparam logic [11:0] SERIAL_PERIPH_C_VECTOR    = 12'h030;
  localparam logic [11:0] TIMER_F_TYPE0_VECTOR_BASE = 12'h0D8;

  // Source slot i takes entry i of this table
  localparam int unsigned MAX_SRC = 8;
  localparam logic [7:0][11:0] SRC_BASE_TBL = {
    12'h032, SERIAL_PERIPH_C_VECTOR, 12'h028, TIMER_C_TYPE0_VECTOR_BASE,
    12'h018, 12'h014, 12'h008, PORT_C_VECTOR_BASE};

  typedef enum logic [1:0] {
    LVL_LO,
    LVL_MED,
    LVL_HI,
    LVL_NMI
  } mlic_level_type;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_FLAGS    = 12'h008;
  localparam logic [11:0] REG_MASK     = 12'h00C;
  localparam logic [11:0] REG_SRC_BASE = 12'h040;

  localparam int unsigned CTRL_RR_EN    = 3;
  localparam int unsigned CTRL_BOOT_SEL = 4;
  localparam logic [4:0]  CTRL_RST      = 5'h00;

  localparam int unsigned CFG_EN_POS  = 0;
  localparam int unsigned CFG_LVL_POS = 1;
  localparam int unsigned CFG_VEC_POS = 16;
  localparam int unsigned STS_LAST_POS = 8;

  localparam int unsigned FLG_ACK     = 0;
  localparam int unsigned FLG_PREEMPT = 1;
  localparam int unsigned FLG_NMI     = 2;
  localparam logic [2:0]  FLG_RST     = 3'h0;

endpackage

// ==== hdl/mlic_top.sv ====
// Summary of operation
// - Sources request only while enabled and pending
// - Each source picks low, medium or high
// - Medium request preempts a running low handler
// - High request preempts medium and low handlers
// - Same level: smallest vector address wins
// - Optional round-robin among low-level requests
// - Oscillator failure is non-maskable, vector 0x002
// - Acknowledge hands the vector to the core
// - Vector is peripheral base plus offset
// - Vectors are program word addresses
// - Table relocates to application or boot start
// - Base vectors follow the fixed map
// - Single-interrupt peripheral uses its table address
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

module mlic_top import mlic_pkg::*; #(
  parameter int unsigned       NUM_SRC   = 8,
  parameter logic [VEC_W-1:0]  BOOT_BASE = 12'h800,
  parameter logic [4*8-1:0]    SRC_OFS   = '0
) (
  input  wire logic               clk_i,       // System clock, 20 MHz
  input  wire logic               rstn_i,      // Async reset, active low
  input  wire logic               psel_i,      // APB select
  input  wire logic               penable_i,   // APB enable
  input  wire logic               pwrite_i,    // APB direction
  input  wire logic [11:0]        paddr_i,     // APB byte address
  input  wire logic [31:0]        pwdata_i,    // APB write data
  output logic                    pready_o,    // APB ready
  output logic [31:0]             prdata_o,    // APB read data
  output logic                    pslverr_o,   // APB error
  input  wire logic [NUM_SRC-1:0] irq_req_i,   // Peripheral conditions
  input  wire logic               osc_fail_i,  // Oscillator failure
  input  wire logic               cpu_ack_i,   // Core takes vector
  input  wire logic               cpu_reti_i,  // Core returns
  output logic                    irq_valid_o, // Vector offered
  output logic [VEC_W-1:0]        vector_o,    // Word address
  output logic [1:0]              level_o,     // Offered level
  output logic [2:0]              src_o,       // Offered source
  output logic                    irq_o        // Flag interrupt
);

  localparam int unsigned IDXW = 3;

  // Slot table and index width hold eight sources at most
  if (NUM_SRC < 2 || NUM_SRC > MAX_SRC) begin : g_bad_num_src
    $error("NUM_SRC must lie between 2 and 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]               osc_sync;
    logic [4:0]               ctrl;
    logic [NUM_SRC-1:0]       en;
    logic [NUM_SRC-1:0][1:0]  lvl;
    logic [3:0]               active;
    logic [IDXW-1:0]          last_lo;
    logic [2:0]               flags;
    logic [2:0]               mask;
    logic                     irq;
    logic                     irq_valid;
    logic [VEC_W-1:0]         vector;
    logic [1:0]               level;
    logic [IDXW-1:0]          src;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } mlic_state_type;

  mlic_state_type q;
  mlic_state_type d;

  logic [NUM_SRC-1:0][VEC_W-1:0] src_vec;
  logic [NUM_SRC-1:0]            req_eff;
  logic [2:0][NUM_SRC-1:0]       lvl_req;
  logic [2:0]                    arb_v;
  logic [2:0][IDXW-1:0]          arb_idx;

  // ----------------------------------------------------------------
  // Request qualification and per-level arbitration
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      src_vec[i] = SRC_BASE_TBL[i] + {8'h00, SRC_OFS[i*4 +: 4]};
    end
  end

  assign req_eff = irq_req_i & q.en;

  generate
    for (genvar l = 0; l < 3; l++) begin : g_lvl
      for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        // Level-enable bits sit at the level's own code in CTRL
        assign lvl_req[l][i] = req_eff[i] && (q.lvl[i] == 2'(l)) && q.ctrl[l];
      end
      mlic_level_arb #(
        .N  (NUM_SRC),
        .IW (IDXW)
      ) u_arb (
        .req_i   (lvl_req[l]),
        .vec_i   (src_vec),
        .rr_en_i (l == 0 && q.ctrl[CTRL_RR_EN]),
        .last_i  (q.last_lo),
        .valid_o (arb_v[l]),
        .idx_o   (arb_idx[l])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                 win_v;
    logic [1:0]           win_lvl;
    logic [IDXW-1:0]      win_idx;
    logic [VEC_W-1:0]     reloc;
    logic [VEC_W-1:0]     tbl_vec;
    logic                 acc;
    logic                 ack;
    logic [11:0]          off;
    logic                 cfg_hit;
    logic [IDXW-1:0]      ci;
    logic [1:0]           wlvl;
    win_v   = 1'b0;
    win_lvl = LVL_LO;
    win_idx = '0;
    reloc   = '0;
    tbl_vec = '0;
    acc     = psel_i & penable_i;
    ack     = cpu_ack_i & q.irq_valid;
    off     = paddr_i - REG_SRC_BASE;
    cfg_hit = (paddr_i >= REG_SRC_BASE) && (off[11:2] < 10'(NUM_SRC))
              && (off[1:0] == 2'b00);
    ci      = off[2 +: IDXW];
    wlvl    = pwdata_i[CFG_LVL_POS +: 2];
    d       = q;

    d.osc_sync = {q.osc_sync[0], osc_fail_i};

    // Winner: a level is eligible only above every active level
    if (q.osc_sync[1] && !q.active[LVL_NMI]) begin
      win_v   = 1'b1;
      win_lvl = LVL_NMI;
    end else if (arb_v[2] && q.active[3:2] == 2'b00) begin
      win_v   = 1'b1;
      win_lvl = LVL_HI;
      win_idx = arb_idx[2];
    end else if (arb_v[1] && q.active[3:1] == 3'b000) begin
      win_v   = 1'b1;
      win_lvl = LVL_MED;
      win_idx = arb_idx[1];
    end else if (arb_v[0] && q.active == 4'h0) begin
      win_v   = 1'b1;
      win_lvl = LVL_LO;
      win_idx = arb_idx[0];
    end

    if (q.ctrl[CTRL_BOOT_SEL]) begin
      reloc = BOOT_BASE;
    end
    tbl_vec = (win_lvl == LVL_NMI) ? OSC_FAIL_VECTOR : src_vec[win_idx];

    // Return clears only the topmost active level
    if (cpu_reti_i) begin
      if (q.active[3]) begin
        d.active[3] = 1'b0;
      end else if (q.active[2]) begin
        d.active[2] = 1'b0;
      end else if (q.active[1]) begin
        d.active[1] = 1'b0;
      end else begin
        d.active[0] = 1'b0;
      end
    end

    // Offer is withdrawn in the ack cycle so it is not taken twice
    if (ack) begin
      d.irq_valid       = 1'b0;
      d.active[q.level] = 1'b1;
      if (q.level == LVL_LO) begin
        d.last_lo = q.src;
      end
    end else begin
      d.irq_valid = win_v;
      d.vector    = reloc + tbl_vec;
      d.level     = win_lvl;
      d.src       = win_idx;
    end

    // ---------------- APB slave ----------------
    // Answer one edge into the access phase; write effects one edge later
    d.pready = acc & ~q.pready;
    if (acc & ~q.pready) begin
      d.pslverr = 1'b0;
      d.prdata  = '0;
      if (paddr_i == REG_CTRL) begin
        d.prdata[4:0] = q.ctrl;
      end else if (paddr_i == REG_STATUS) begin
        d.prdata[3:0] = q.active;
        d.prdata[STS_LAST_POS +: IDXW] = q.last_lo;
      end else if (paddr_i == REG_FLAGS) begin
        d.prdata[2:0] = q.flags;
      end else if (paddr_i == REG_MASK) begin
        d.prdata[2:0] = q.mask;
      end else if (cfg_hit) begin
        d.prdata[CFG_EN_POS]          = q.en[ci];
        d.prdata[CFG_LVL_POS +: 2]    = q.lvl[ci];
        d.prdata[CFG_VEC_POS +: VEC_W] = src_vec[ci];
      end else begin
        d.pslverr = 1'b1;
      end
    end else if (!acc) begin
      d.pslverr = 1'b0;
      d.prdata  = '0;
    end

    if (acc && q.pready && pwrite_i && !q.pslverr) begin
      if (paddr_i == REG_CTRL) begin
        d.ctrl = pwdata_i[4:0];
      end else if (paddr_i == REG_MASK) begin
        d.mask = pwdata_i[2:0];
      end else if (cfg_hit) begin
        d.en[ci]  = pwdata_i[CFG_EN_POS];
        // The NMI code is not selectable by software
        d.lvl[ci] = (wlvl == LVL_NMI) ? LVL_HI : wlvl;
      end
    end

    // Flags: read clears, a same-cycle event still lands
    // Clear only what was read; a flag set after the capture survives
    if (acc && q.pready && !pwrite_i && paddr_i == REG_FLAGS) begin
      d.flags = q.flags & ~q.prdata[2:0];
    end
    if (ack) begin
      d.flags[FLG_ACK] = 1'b1;
      if (q.active != 4'h0) begin
        d.flags[FLG_PREEMPT] = 1'b1;
      end
      if (q.level == LVL_NMI) begin
        d.flags[FLG_NMI] = 1'b1;
      end
    end
    d.irq = |(d.flags & d.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q           <= '0;
      q.ctrl      <= CTRL_RST;
      q.flags     <= FLG_RST;
      q.vector    <= RESET_VECTOR;
    end else begin
      q <= d;
    end
  end

  assign pready_o    = q.pready;
  assign prdata_o    = q.prdata;
  assign pslverr_o   = q.pslverr;
  assign irq_valid_o = q.irq_valid;
  assign vector_o    = q.vector;
  assign level_o     = q.level;
  assign src_o       = q.src;
  assign irq_o       = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_NO_ENABLED_NO_OFFER: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (q.en == '0 && !q.osc_sync[1] && !q.osc_sync[0]) |=> !irq_valid_o)
    else $error("offer without any enabled source");

  AST_NMI_VECTOR: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_valid_o && level_o == LVL_NMI) |->
      vector_o == OSC_FAIL_VECTOR + ($past(q.ctrl[CTRL_BOOT_SEL]) ? BOOT_BASE : 12'h000))
    else $error("wrong NMI vector");

  AST_NO_EQUAL_PREEMPT: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_valid_o && !$past(cpu_reti_i)) |-> ($past(q.active) >> level_o) == 4'h0)
    else $error("offer at or below an active level");

  AST_MED_OVER_LO: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (q.active == 4'h1 && arb_v[1] && !q.irq_valid && !cpu_reti_i)
      |=> irq_valid_o && level_o != LVL_LO)
    else $error("medium request did not preempt low handler");

  AST_HI_OVER_MED: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (q.active[3:1] == 3'b001 && arb_v[2] && !q.irq_valid && !cpu_reti_i)
      |=> irq_valid_o && level_o[1])
    else $error("high request did not preempt medium handler");

  AST_ACK_SETS_ACTIVE: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cpu_ack_i && irq_valid_o && !cpu_reti_i)
      |=> q.active[$past(level_o)] && !irq_valid_o)
    else $error("acknowledge not recorded");

  AST_RETI_TOPMOST: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cpu_reti_i && !cpu_ack_i && q.active[3])
      |=> q.active == {1'b0, $past(q.active[2:0])})
    else $error("return cleared the wrong level");

  AST_WORD_VECTOR: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_valid_o && level_o != LVL_NMI && !$past(q.ctrl[CTRL_BOOT_SEL]))
      |-> vector_o == src_vec[src_o])
    else $error("vector is not base plus offset");

  AST_RR_LAST: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cpu_ack_i && irq_valid_o && level_o == LVL_LO) |=> q.last_lo == $past(src_o))
    else $error("round-robin pointer not updated");

  AST_RETI_HI: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cpu_reti_i && !cpu_ack_i && q.active[3:2] == 2'b01)
      |=> q.active == {2'b00, $past(q.active[1:0])})
    else $error("return did not clear the high level");

  AST_OFFER_ENABLED: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (irq_valid_o && level_o != LVL_NMI)
      |-> |($past(req_eff) & (NUM_SRC'(1) << src_o)))
    else $error("offer for a source not enabled and pending");

  AST_ACK_FLAG: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (cpu_ack_i && irq_valid_o) |=> q.flags[FLG_ACK])
    else $error("acknowledge flag lost");

  AST_NMI_NO_NEST: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    q.active[LVL_NMI] |-> !(irq_valid_o && level_o == LVL_NMI))
    else $error("nested non-maskable offer");

endmodule // mlic_top

// ==== sim/mlic_core_model.sv ====
`timescale 1ns/1ps

// ----
// Core side: takes offered vectors
// ----
module mlic_core_model (
  input  wire logic        clk_i,    // System clock
  input  wire logic        rstn_i,   // Reset, active low
  input  wire logic        valid_i,  // Vector offered
  input  wire logic [11:0] vector_i, // Offered vector
  input  wire logic [1:0]  level_i,  // Offered level
  input  wire logic [2:0]  src_i,    // Offered source
  input  wire logic        ack_en_i, // Core may take
  input  wire logic [3:0]  dly_i,    // Wait before ack
  input  wire logic        reti_i,   // Return request
  output logic             ack_o,    // Take pulse
  output logic             reti_o,   // Return pulse
  output logic [7:0]       taken_o,  // Vectors taken
  output logic [16:0]      pc_o      // Level, source, vector
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q   <= 4'h0;
      ack_o   <= 1'b0;
      reti_o  <= 1'b0;
      taken_o <= 8'h00;
      pc_o    <= 17'h00000;
    end else begin
      reti_o <= reti_i;
      // Ack held until seen with the offer
      if (ack_o && valid_i) begin
        ack_o   <= 1'b0;
        cnt_q   <= 4'h0;
        taken_o <= taken_o + 8'h01;
        pc_o    <= {level_i, src_i, vector_i};
      end else if (valid_i && ack_en_i && !ack_o) begin
        if (cnt_q >= dly_i) begin
          ack_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (!valid_i) begin
        cnt_q <= 4'h0;
      end
    end
  end
endmodule // mlic_core_model

// ==== sim/tb_multilevel_interrupt_controller.sv ====
`timescale 1ns/1ps

module tb_multilevel_interrupt_controller;
  import mlic_pkg::*;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic        osc = 0, ack_en = 0, reti = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic [7:0]  req = '0;
  logic [3:0]  dly = 4'h0;
  wire logic        pready, pslverr, ack, cret, valid, irq;
  wire logic [31:0] prdata;
  wire logic [11:0] vec;
  wire logic [1:0]  lvl;
  wire logic [2:0]  src;
  wire logic [7:0]  taken;
  wire logic [16:0] pc;
  int          fails = 0, n_checks = 0;

  always #25 clk = ~clk;

  // Offset 2 on slot 4 so the sum is visible
  mlic_top #(.NUM_SRC(8), .BOOT_BASE(12'h800), .SRC_OFS(32'h0002_0000)) dut (
    .clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .irq_req_i(req), .osc_fail_i(osc), .cpu_ack_i(ack),
    .cpu_reti_i(cret), .irq_valid_o(valid), .vector_o(vec), .level_o(lvl),
    .src_o(src), .irq_o(irq));

  mlic_core_model core (
    .clk_i(clk), .rstn_i(rstn), .valid_i(valid), .vector_i(vec), .level_i(lvl),
    .src_i(src), .ack_en_i(ack_en), .dly_i(dly), .reti_i(reti), .ack_o(ack),
    .reti_o(cret), .taken_o(taken), .pc_o(pc));

  // ----
  // Shared tasks
  // ----
  task final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No assumed latency; the watchdog bounds a stuck slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask

  task cfg(input int i, input logic [1:0] l);
    apb(1'b1, REG_SRC_BASE + 12'(4 * i), {29'h0, l, 1'b1});
  endtask

  task rst();
    @(posedge clk);
    rstn   <= 1'b0;
    req    <= 8'h00;
    osc    <= 1'b0;
    ack_en <= 1'b0;
    dly    <= 4'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  // Bounded wait for the core to take one vector
  task take(input logic [16:0] e);
    int n;
    logic [7:0] t0;
    n = 0;
    @(negedge clk);
    t0 = taken;
    @(posedge clk);
    ack_en <= 1'b1;
    while (taken === t0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    ack_en <= 1'b0;
    chk("taken vector", {15'h0, pc}, {15'h0, e});
  endtask

  task none();
    repeat (6) @(negedge clk);
    chk("no offer", 32'(valid), 32'h0);
  endtask

  task rt();
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ----
  // Scenarios
  // ----
  task t_regs();
    int i;
    logic [31:0] e;
    rst();
    rdc("ctrl reset", REG_CTRL, 32'h1F, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    apb(1'b1, REG_MASK, 32'h5);
    rdc("mask", REG_MASK, 32'h7, 32'h5);
    apb(1'b1, REG_SRC_BASE, 32'h7);
    rdc("src level", REG_SRC_BASE, 32'h7, 32'h5);
    // Slot 4 carries the offset of 2 set at the instance
    for (i = 0; i < 8; i++) begin
      e = {4'h0, SRC_BASE_TBL[i] + ((i == 4) ? 12'h002 : 12'h000), 16'h0};
      rdc("table", REG_SRC_BASE + 12'(4 * i), 32'h0FFF_0000, e);
    end
  endtask

  task t_enable();
    rst();
    apb(1'b1, REG_CTRL, 32'h7);
    req[3] <= 1'b1;
    none();
    cfg(3, 2'd0);
    take({2'd0, 3'd3, 12'h018});
  endtask

  task t_order();
    int l;
    for (l = 0; l < 3; l++) begin
      rst();
      apb(1'b1, REG_CTRL, 32'h7);
      cfg(6, l[1:0]);
      cfg(2, l[1:0]);
      req <= 8'h44;
      take({l[1:0], 3'd2, 12'h014});
    end
  endtask

  task t_preempt();
    rst();
    apb(1'b1, REG_CTRL, 32'h7);
    cfg(5, 2'd0);
    cfg(3, 2'd1);
    cfg(1, 2'd2);
    cfg(0, 2'd1);
    dly    <= 4'h3;
    req[5] <= 1'b1;
    take({2'd0, 3'd5, 12'h028});
    req[5] <= 1'b0;
    dly    <= 4'h0;
    req[3] <= 1'b1;
    take({2'd1, 3'd3, 12'h018});
    req[3] <= 1'b0;
    rdc("preempt flag", REG_FLAGS, 32'h3, 32'h3);
    req[1] <= 1'b1;
    take({2'd2, 3'd1, 12'h008});
    req[1] <= 1'b0;
    req[0] <= 1'b1;
    none();
    rdc("active levels", REG_STATUS, 32'hF, 32'h7);
    rt();
    none();
    rt();
    take({2'd1, 3'd0, 12'h004});
  endtask

  task t_rr();
    rst();
    apb(1'b1, REG_CTRL, 32'hF);
    cfg(1, 2'd0);
    cfg(3, 2'd0);
    cfg(6, 2'd0);
    req <= 8'h4A;
    take({2'd0, 3'd1, 12'h008});
    rt();
    take({2'd0, 3'd3, 12'h018});
    rt();
    take({2'd0, 3'd6, 12'h030});
    rt();
    take({2'd0, 3'd1, 12'h008});
    rdc("last low", REG_STATUS, 32'h700, 32'h100);
  endtask

  // Levels left disabled: only the non-maskable path can answer
  task t_nmi();
    rst();
    osc <= 1'b1;
    take({2'd3, 3'd0, OSC_FAIL_VECTOR});
    osc <= 1'b0;
    rdc("nmi flag", REG_FLAGS, 32'h4, 32'h4);
    rt();
    rdc("nmi return", REG_STATUS, 32'hF, 32'h0);
  endtask

  task t_boot();
    rst();
    apb(1'b1, REG_CTRL, 32'h17);
    cfg(4, 2'd2);
    req[4] <= 1'b1;
    take({2'd2, 3'd4, 12'h81E});
  endtask

  task t_irq();
    rst();
    apb(1'b1, REG_CTRL, 32'h7);
    cfg(7, 2'd0);
    req[7] <= 1'b1;
    take({2'd0, 3'd7, 12'h032});
    repeat (3) @(negedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, REG_MASK, 32'h1);
    repeat (3) @(negedge clk);
    chk("irq raised", 32'(irq), 32'h1);
    rdc("ack flag", REG_FLAGS, 32'h1, 32'h1);
    repeat (3) @(negedge clk);
    chk("irq cleared", 32'(irq), 32'h0);
  endtask

  initial begin
    t_regs();
    t_enable();
    t_order();
    t_preempt();
    t_rr();
    t_nmi();
    t_boot();
    t_irq();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule // tb_multilevel_interrupt_controller
